//--- onoff_pkg.sv
// Notes on behaviour
// (R1) each rising serial clock edge, except the first after a latch rise, stores serial_in into the shift register bit 0
// (R2) each rising serial clock edge, except the first after a latch rise, moves all shift bits one place toward bit 15
// (R3) controller waits at least 100 ns after latch rise before a serial clock edge
// (R4) latch rising edge copies the whole shift register into the on/off latch
// (R5) latch rising edge reloads the shift register with open-LED and thermal status; the code reloads on the first serial clock edge after it
// (R6) controller pulses the latch only once after each shifted update
// (R7) while blanking is high all sixteen sink channels are off
// (R8) while blanking is low each sink channel follows its on/off latch bit
// (R9) blanking rise captures status; captured status is shown while blanking is low
// (R10) serial_out comes directly from shift register bit 15
// (R11) serial_out changes only on a rising serial clock edge
// (R12) sixteen-bit register and latch; bit n drives channel n; one means on
// (R13) status word holds the open flags of channels 14..0 and the thermal flag at bit 15
package onoff_pkg;

	localparam int unsigned CHANNELS = 16;
	localparam int unsigned MSB_BIT  = CHANNELS - 1;

	// shift-word layout of the reloaded status: thermal flag on top,
	// open flags of channels 14..0 below it
	localparam int unsigned THERMAL_BIT = 15;
	localparam int unsigned OPEN_TOP    = 14;

	localparam logic [CHANNELS-1:0] WORD_RESET = 16'h0000;
	localparam logic                BIT_RESET  = 1'b0;

	// quiet time the controller keeps after a latch rise
	localparam int unsigned LATCH_QUIET_NS = 100;
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned LATCH_QUIET_CYC =
		(LATCH_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic                thermal;
		logic [CHANNELS-1:0] open_led;
	} status_type;

	localparam status_type STATUS_RESET = '{thermal: 1'b0, open_led: 16'h0000};

endpackage

//--- level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// level in from another domain, level out in this one
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q   <= '0;
			stable_q <= '0;
		end else begin
			meta_q   <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;

endmodule
`default_nettype wire

//--- led_onoff_shift_latch.sv
`timescale 1ns/1ps
`default_nettype none
module led_onoff_shift_latch (
	// system clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// serial link, clocked by the controller
	input  wire logic                           serial_clk,
	input  wire logic                           serial_in,
	output logic                                serial_out,
	// control pins
	input  wire logic                           latch_strobe,
	input  wire logic                           blanking,
	// status sense inputs
	input  wire logic [onoff_pkg::CHANNELS-1:0] open_led_flag,
	input  wire logic                           thermal_warning_flag,
	// outputs
	output logic      [onoff_pkg::CHANNELS-1:0] sink_channel,
	output onoff_pkg::status_type               status_capture
);

	////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic                         rst_sclk_n;
	logic                         latch_s;
	logic                         blank_s;
	onoff_pkg::status_type        status_raw;
	onoff_pkg::status_type        status_s;

	assign status_raw = '{thermal: thermal_warning_flag,
	                      open_led: open_led_flag};

	level_sync #(.WIDTH(1)) u_rst_sclk (
		.clk      (serial_clk),
		.rst_n    (1'b1),
		.async_in (rst_n),
		.sync_out (rst_sclk_n)
	);

	level_sync #(.WIDTH(2)) u_ctrl_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({latch_strobe, blanking}),
		.sync_out ({latch_s, blank_s})
	);

	level_sync #(.WIDTH($bits(onoff_pkg::status_type))) u_stat_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (status_raw),
		.sync_out (status_s)
	);

	////////////////////////////////////////////////////////////////////////
	// system clock domain: edge detect, latches, outputs

	logic                         latch_d1_q;
	logic                         blank_d1_q;
	logic [onoff_pkg::CHANNELS-1:0] onoff_q;
	logic [onoff_pkg::CHANNELS-1:0] reload_word_q;
	logic                         reload_tgl_q;
	onoff_pkg::status_type        cap_q;
	logic [onoff_pkg::CHANNELS-1:0] sink_q;
	onoff_pkg::status_type        stat_out_q;
	logic [onoff_pkg::CHANNELS-1:0] shift_q;

	wire latch_rise = latch_s & ~latch_d1_q;
	wire blank_rise = blank_s & ~blank_d1_q;

	// status word laid into the shift register on reload
	wire [onoff_pkg::CHANNELS-1:0] status_word = {
		status_s.thermal,                            // R13
		status_s.open_led[onoff_pkg::OPEN_TOP:0]     // R13
	};

	wire [onoff_pkg::CHANNELS-1:0] sink_d =
		blank_s ? onoff_pkg::WORD_RESET : onoff_q;   // R7 R8

	wire onoff_pkg::status_type stat_out_d =
		blank_s ? onoff_pkg::STATUS_RESET : cap_q;   // R9

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch_d1_q <= onoff_pkg::BIT_RESET;
			blank_d1_q <= onoff_pkg::BIT_RESET;
		end else begin
			latch_d1_q <= latch_s;
			blank_d1_q <= blank_s;
		end
	end

	// shift_q is read here as a quasi-static word: the controller keeps
	// serial_clk quiet after the latch rise far longer than sync latency
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			onoff_q       <= onoff_pkg::WORD_RESET;
			reload_word_q <= onoff_pkg::WORD_RESET;
			reload_tgl_q  <= onoff_pkg::BIT_RESET;
		end else if (latch_rise) begin
			onoff_q       <= shift_q;                // R4 R12
			reload_word_q <= status_word;            // R5
			reload_tgl_q  <= ~reload_tgl_q;          // R5
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_q <= onoff_pkg::STATUS_RESET;
		end else if (blank_rise) begin
			cap_q <= status_s;                       // R9
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sink_q     <= onoff_pkg::WORD_RESET;
			stat_out_q <= onoff_pkg::STATUS_RESET;
		end else begin
			sink_q     <= sink_d;
			stat_out_q <= stat_out_d;
		end
	end

	assign sink_channel   = sink_q;
	assign status_capture = stat_out_q;

	////////////////////////////////////////////////////////////////////////
	// serial clock domain: shift register

	logic reload_ack_q;

	// the reload toggle and word are held steady through the quiet time
	// the controller keeps after a latch rise, so they are taken as is
	wire reload_pend = reload_tgl_q ^ reload_ack_q;

	wire [onoff_pkg::CHANNELS-1:0] shift_d = reload_pend ?
		reload_word_q :                                          // R5
		{shift_q[onoff_pkg::MSB_BIT-1:0], serial_in};            // R1 R2

	always_ff @(posedge serial_clk) begin
		if (!rst_sclk_n) begin
			shift_q      <= onoff_pkg::WORD_RESET;
			reload_ack_q <= onoff_pkg::BIT_RESET;
		end else begin
			shift_q      <= shift_d;
			reload_ack_q <= reload_tgl_q;
		end
	end

	assign serial_out = shift_q[onoff_pkg::MSB_BIT];   // R10 R11

	////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_latch_seen;
		latch_rise;
	endsequence

	sequence s_blank_low2;
		!blank_s [*2];
	endsequence

	property p_blank_off;
		@(posedge clk) disable iff (!rst_n)
		blank_s |=> (sink_channel == onoff_pkg::WORD_RESET);
	endproperty

	property p_follow;
		@(posedge clk) disable iff (!rst_n)
		!blank_s |=> (sink_channel == $past(onoff_q));
	endproperty

	AST_BLANK_OFF: assert property (p_blank_off) // R7
		else $error("sink on while blanking high");

	AST_FOLLOW_LATCH: assert property (p_follow) // R8
		else $error("sink differs from on/off latch");

	AST_LATCH_COPY: assert property ( // R4
		@(posedge clk) disable iff (!rst_n)
		s_latch_seen |=> (onoff_q == $past(shift_q)))
		else $error("latch did not copy shift word");

	AST_LATCH_TWO_STEP: assert property ( // R4
		@(posedge clk) disable iff (!rst_n)
		s_latch_seen ##1 !blank_s |=> (sink_channel == $past(onoff_q)))
		else $error("latched word not on sinks");

	AST_RELOAD_REQ: assert property ( // R5
		@(posedge clk) disable iff (!rst_n)
		s_latch_seen |=> (reload_tgl_q != $past(reload_tgl_q))
		         && (reload_word_q == $past(status_word)))
		else $error("status reload not requested");

	AST_STATUS_CAP: assert property ( // R9
		@(posedge clk) disable iff (!rst_n)
		blank_rise |=> (cap_q == $past(status_s)))
		else $error("status not captured on blanking rise");

	AST_STATUS_SHOW: assert property ( // R9
		@(posedge clk) disable iff (!rst_n)
		s_blank_low2 |-> (status_capture == $past(cap_q)))
		else $error("captured status not shown");

	AST_SHIFT_IN: assert property ( // R1 R2
		@(posedge serial_clk) disable iff (!rst_sclk_n)
		!reload_pend |=> (shift_q == {$past(shift_q[onoff_pkg::MSB_BIT-1:0]),
		                              $past(serial_in)}))
		else $error("shift register did not shift");

	AST_RELOAD_APPLY: assert property ( // R5
		@(posedge serial_clk) disable iff (!rst_sclk_n)
		reload_pend |=> (shift_q == $past(reload_word_q)) && !reload_pend)
		else $error("status word not loaded");

	AST_SERIAL_OUT: assert property ( // R10 R11
		@(posedge serial_clk) disable iff (!rst_sclk_n)
		!reload_pend |=> (serial_out == $past(shift_q[onoff_pkg::MSB_BIT-1])))
		else $error("serial_out not from top bit");

endmodule
`default_nettype wire

//--- link_driver.sv
`timescale 1ns/1ps
`default_nettype none
module link_driver (
	// serial link toward the device
	output logic serial_clk,
	output logic serial_in
);
	initial begin
		serial_clk = 1'b0;
		serial_in  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one frame: an optional reload edge, then 16 bits, msb first, 6 ns
	// per bit; the clock rests low between frames
	task automatic send_word(input logic [15:0] w, input logic reload);
		#1.3;
		if (reload) begin
			serial_in = ~serial_in;
			#3 serial_clk = 1'b1;
			#3 serial_clk = 1'b0;
		end
		for (int i = 15; i >= 0; i--) begin
			serial_in = w[i];
			#3 serial_clk = 1'b1;
			#3 serial_clk = 1'b0;
		end
		// no stale data left on an idle line
		serial_in = ~serial_in;
	endtask
endmodule
`default_nettype wire

//--- led_onoff_shift_latch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module led_onoff_shift_latch_tb_top;
	logic clk, rst_n, ser_clk, ser_in, ser_out, lat, blank, therm;
	logic [15:0] open_f, sink, sh, stat_w;
	onoff_pkg::status_type stat;
	logic pend;
	int seed, miscompares, samples_checked;
	logic exp_q[$];

	led_onoff_shift_latch led_onoff_shift_latch_inst (.clk(clk),
		.rst_n(rst_n), .serial_clk(ser_clk), .serial_in(ser_in),
		.serial_out(ser_out), .latch_strobe(lat), .blanking(blank),
		.open_led_flag(open_f), .thermal_warning_flag(therm),
		.sink_channel(sink), .status_capture(stat));
	link_driver link_driver_inst (.serial_clk(ser_clk), .serial_in(ser_in));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check_vec(input string n, input logic [16:0] e,
		input logic [16:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check_bit(input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value serial_out expected %b seen %b", e, g);
		end
	endtask

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// serial_out is looked at just after each serial clock rise
	initial begin
		forever begin
			@(posedge ser_clk);
			#1;
			if (exp_q.size() > 0)
				check_bit(exp_q.pop_front(), ser_out);
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic frame(input logic [15:0] w);
		if (pend) begin
			sh = stat_w;
			exp_q.push_back(sh[15]);
		end
		for (int i = 15; i >= 0; i--) begin
			sh = {sh[14:0], w[i]};
			exp_q.push_back(sh[15]);
		end
		link_driver_inst.send_word(w, pend);
		pend = 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic do_latch(input logic [15:0] w);
		@(posedge clk);
		lat <= 1'b1;
		stat_w = {therm, open_f[14:0]};
		pend = 1'b1;
		repeat (2) @(posedge clk);
		lat <= 1'b0;
		repeat (3) @(posedge clk);
		check_vec("sink_channel", {1'b0, w}, {1'b0, sink});
		// serial clock kept quiet well past 100 ns after the latch rise
		repeat (20) @(posedge clk);
	endtask

	task automatic blank_test(input logic [15:0] w);
		logic [16:0] cap;
		@(posedge clk);
		blank <= 1'b1;
		cap = {therm, open_f};
		repeat (5) @(posedge clk);
		check_vec("sink_channel", 17'h00000, {1'b0, sink});
		check_vec("status_capture", 17'h00000, stat);
		open_f <= 16'($random(seed));
		therm <= 1'($random(seed));
		blank <= 1'b0;
		repeat (5) @(posedge clk);
		check_vec("status_capture", cap, stat);
		check_vec("sink_channel", {1'b0, w}, {1'b0, sink});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] w;
		seed = 32'h6efe;
		rst_n = 1'b0;
		lat = 1'b0;
		blank = 1'b0;
		therm = 1'b0;
		open_f = 16'h0000;
		pend = 1'b0;
		sh = 16'h0000;
		// the serial domain needs its clock running to leave reset
		fork
			link_driver_inst.send_word(16'h0000, 1'b0);
		join_none
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		link_driver_inst.send_word(16'h0000, 1'b0);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 16'h8001 :
				(i == 1) ? 16'hffff : 16'($random(seed));
			open_f <= 16'($random(seed));
			therm <= 1'($random(seed));
			repeat (4) @(posedge clk);
			frame(w);
			do_latch(w);
			blank_test(w);
			$display("test %0d done", i);
		end
		frame(16'h0000);
		// a lost serial edge would leave notes behind unchecked
		check_vec("serial notes left", 17'h00000, 17'(exp_q.size()));
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule
`default_nettype wire
